//--- rtl/rstc_controller.v
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rstc_regs.vh"

module rstc_controller #(
    parameter CLKLOSS_CYCLES = `RSTC_CLKLOSS_CYCLES,
    parameter HOLD_CYCLES    = `RSTC_HOLD_CYCLES,
    parameter WDOG_LIMIT     = `RSTC_WDOG_LIMIT
) (
    // Clock, reset, clock enable
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // External reset pin and system reset out
    input  wire        ext_rst_n,
    output reg         sys_rst_n,
    // Clock-loss and comparator
    input  wire        system_clock,
    input  wire        comparator_out,
    // Flash access monitor
    input  wire        flash_write_enable,
    input  wire        xdata_wr_valid,
    input  wire        code_rd_valid,
    input  wire        fetch_valid,
    input  wire [15:0] access_addr,
    input  wire        security_violation,
    input  wire        flash_wr_erase_req,
    output wire        supply_monitor_en,
    // USB
    input  wire        usb_enabled,
    input  wire        usb_bus_reset,
    input  wire        vbus_level,
    input  wire        vbus_polarity_select,
    // Watchdog state
    output wire        watchdog_active
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam ST_RUN   = 1'b0;
    localparam ST_RESET = 1'b1;

    // Sized compare values; the hold counter is 16 bits wide, so
    // HOLD_CYCLES above 65536 would wrap and shorten the reset.
    localparam [3:0]  DIV_LAST  = `RSTC_WDOG_PRESCALE - 1;
    localparam [15:0] HOLD_LAST = HOLD_CYCLES - 1;

    reg         state_q;
    reg  [15:0] hold_q;
    reg  [7:0]  flags_q;
    reg  [7:0]  cause_q;
    reg         en_clkloss_q;
    reg         en_cmp_q;
    reg         en_usb_q;
    reg         wd_en_q;
    reg         sup_en_q;
    reg         system_clock_q;
    reg  [3:0]  div_q;
    reg         soft_req;
    reg         wd_kick;
    reg  [7:0]  req;

    wire        wr_en;
    wire        rd_en;
    wire        system_clock_edge;
    wire        wd_tick;
    wire        clkloss_exp;
    wire        wdog_exp;
    wire        above_user;
    wire        flash_err;
    wire        usb_cond;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `RSTC_CAUSE_ADDR) || (a == `RSTC_WDCTL_ADDR) ||
                     (a == `RSTC_SUPPLY_ADDR);
        end
    endfunction

    function is_addr;
        input [11:0] a;
        input [11:0] target;
        begin
            is_addr = (a == target);
        end
    endfunction

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // Zero wait state; a frozen clock enable stretches the access
    assign pready  = ce;
    assign pslverr = psel && penable && !mapped(paddr);
    assign wr_en   = psel && penable && pwrite && ce && mapped(paddr) &&
                     (state_q == ST_RUN);
    assign rd_en   = psel && !penable && !pwrite;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (ce && rd_en)
        begin
            if (is_addr(paddr, `RSTC_CAUSE_ADDR))
                prdata <= {24'h000000, flags_q};
            else if (is_addr(paddr, `RSTC_WDCTL_ADDR))
                prdata <= {30'h0, wdog_exp, wd_en_q};
            else if (is_addr(paddr, `RSTC_SUPPLY_ADDR))
                prdata <= {31'h0, sup_en_q};
            else
                prdata <= 32'h00000000;
        end
    end

    always @*
    begin
        soft_req = wr_en && is_addr(paddr, `RSTC_CAUSE_ADDR) &&
                   pwdata[`RSTC_B_SOFT];
        wd_kick  = wr_en && is_addr(paddr, `RSTC_WDCTL_ADDR) &&
                   pwdata[`RSTC_B_WD_KICK];
    end

    // ------------------------------------------------------------------
    // Enables (shared flag/enable positions)
    // ------------------------------------------------------------------
    // Any system reset drops the clock-loss, comparator and USB enables and sets the watchdog enable,
    // so a stale enable cannot trigger a second reset straight after release.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_clkloss_q <= 1'b0;
            en_cmp_q     <= 1'b0;
            en_usb_q     <= 1'b0;
            wd_en_q      <= 1'b1;
            sup_en_q     <= 1'b1;
        end
        else if (ce)
        begin
            if (state_q == ST_RESET)
            begin
                en_clkloss_q <= 1'b0;
                en_cmp_q     <= 1'b0;
                en_usb_q     <= 1'b0;
                wd_en_q      <= 1'b1;
            end
            else if (wr_en && is_addr(paddr, `RSTC_CAUSE_ADDR))
            begin
                en_clkloss_q <= pwdata[`RSTC_B_CLKLOSS];
                en_cmp_q     <= pwdata[`RSTC_B_CMP];
                en_usb_q     <= pwdata[`RSTC_B_USB];
            end
            else if (wr_en && is_addr(paddr, `RSTC_WDCTL_ADDR))
                wd_en_q <= pwdata[`RSTC_B_WD_EN];
            else if (wr_en && is_addr(paddr, `RSTC_SUPPLY_ADDR))
                sup_en_q <= pwdata[`RSTC_B_SUP_EN];
        end
    end

    assign supply_monitor_en = sup_en_q;

    // ------------------------------------------------------------------
    // System clock edge detect and watchdog prescaler
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            system_clock_q <= 1'b0;
            div_q    <= 4'h0;
        end
        else if (ce)
        begin
            system_clock_q <= system_clock;
            if (state_q == ST_RESET)
                div_q <= 4'h0;
            else if (system_clock_edge)
            begin
                if (div_q == DIV_LAST)
                    div_q <= 4'h0;
                else
                    div_q <= div_q + 4'h1;
            end
        end
    end

    assign system_clock_edge = system_clock && !system_clock_q;
    assign wd_tick     = system_clock_edge &&
                         (div_q == DIV_LAST);

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    // Clock-loss one-shot: restarted by every system clock rising edge
    rstc_timer #(
        .WIDTH (16),
        .LIMIT (CLKLOSS_CYCLES)
    ) u_clkloss (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .en        (en_clkloss_q && state_q == ST_RUN),
        .clear     (system_clock_edge),
        .tick      (1'b1),
        .expired_q (clkloss_exp)
    );

    rstc_timer #(
        .WIDTH (16),
        .LIMIT (WDOG_LIMIT)
    ) u_wdog (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .en        (wd_en_q && state_q == ST_RUN),
        .clear     (wd_kick),
        .tick      (wd_tick),
        .expired_q (wdog_exp)
    );

    assign watchdog_active = wd_en_q;

    // ------------------------------------------------------------------
    // Reset requests
    // ------------------------------------------------------------------
    assign above_user = access_addr > `RSTC_FLASH_TOP;
    assign flash_err  =
        (above_user && ((xdata_wr_valid && flash_write_enable) ||
                        code_rd_valid || fetch_valid)) ||
        security_violation ||
        (flash_wr_erase_req && !sup_en_q);
    assign usb_cond   = (usb_bus_reset && usb_enabled) ||
                        (vbus_level == vbus_polarity_select);

    always @*
    begin
        req = 8'h00;
        req[`RSTC_B_PIN]     = !ext_rst_n;
        req[`RSTC_B_CLKLOSS] = clkloss_exp;
        req[`RSTC_B_WDOG]    = wdog_exp;
        req[`RSTC_B_SOFT]    = soft_req;
        req[`RSTC_B_CMP]     = en_cmp_q && !comparator_out;
        req[`RSTC_B_FLASH]   = flash_err;
        req[`RSTC_B_USB]     = en_usb_q && usb_cond;
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // The pin outranks internal sources so a pin held when a reset starts is always named.
    // The pin is input only here: nothing drives it back out.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q   <= ST_RUN;
            hold_q    <= 16'h0000;
            cause_q   <= 8'h00;
            flags_q   <= `RSTC_CAUSE_RESET;
            sys_rst_n <= 1'b0;
        end
        else if (ce)
        begin
            case (state_q)
                ST_RUN:
                begin
                    sys_rst_n <= 1'b1;
                    hold_q    <= 16'h0000;
                    if (req != 8'h00)
                    begin
                        state_q   <= ST_RESET;
                        sys_rst_n <= 1'b0;
                        if (req[`RSTC_B_PIN])
                            cause_q <= 8'h01 << `RSTC_B_PIN;
                        else
                            cause_q <= req & ~(req - 8'h01);
                    end
                end
                ST_RESET:
                begin
                    sys_rst_n <= 1'b0;
                    if (!ext_rst_n)
                        hold_q <= 16'h0000;
                    else if (hold_q < HOLD_LAST)
                        hold_q <= hold_q + 16'h0001;
                    else
                    begin
                        state_q   <= ST_RUN;
                        sys_rst_n <= 1'b1;
                        flags_q   <= cause_q;
                    end
                end
                default:
                begin
                    state_q   <= ST_RUN;
                    sys_rst_n <= 1'b1;
                end
            endcase
        end
    end

endmodule // rstc_controller

`default_nettype wire

//--- rtl/rstc_regs.vh
`ifndef RSTC_REGS_VH
`define RSTC_REGS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define RSTC_CAUSE_IDX       8'hEF
`define RSTC_WDCTL_IDX       8'hF0
`define RSTC_SUPPLY_IDX      8'hF1
`define RSTC_CAUSE_ADDR      12'h3BC
`define RSTC_WDCTL_ADDR      12'h3C0
`define RSTC_SUPPLY_ADDR     12'h3C4

// ----------------------------------------------------------------------
// Cause register fields
// ----------------------------------------------------------------------
`define RSTC_B_PIN           0
`define RSTC_B_POR           1
`define RSTC_B_CLKLOSS       2
`define RSTC_B_WDOG          3
`define RSTC_B_SOFT          4
`define RSTC_B_CMP           5
`define RSTC_B_FLASH         6
`define RSTC_B_USB           7
`define RSTC_CAUSE_RESET     8'h02

// ----------------------------------------------------------------------
// Watchdog control and supply monitor fields
// ----------------------------------------------------------------------
`define RSTC_B_WD_EN         0
`define RSTC_B_WD_KICK       1
`define RSTC_WDCTL_RESET     8'h01
`define RSTC_B_SUP_EN        0
`define RSTC_SUPPLY_RESET    8'h01

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RSTC_CLK_PERIOD_PS   5000
`define RSTC_CLKLOSS_TIME_NS 100000
`define RSTC_HOLD_TIME_NS    5000
`define RSTC_CLKLOSS_CYCLES  ((`RSTC_CLKLOSS_TIME_NS * 1000) / `RSTC_CLK_PERIOD_PS)
`define RSTC_HOLD_CYCLES     ((`RSTC_HOLD_TIME_NS * 1000 + `RSTC_CLK_PERIOD_PS - 1) / `RSTC_CLK_PERIOD_PS)
`define RSTC_WDOG_PRESCALE   12
`define RSTC_WDOG_LIMIT      256
`define RSTC_FLASH_TOP       16'h3DFF

`endif

//--- rtl/rstc_timer.v
`timescale 1ns/1ps
`default_nettype none

// Saturating timeout counter: counts ticks while enabled, clear restarts
module rstc_timer #(
    parameter WIDTH = 16,
    parameter LIMIT = 256
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    input  wire             ce,
    // Control
    input  wire             en,
    input  wire             clear,
    input  wire             tick,
    // Status
    output reg              expired_q
);

    reg  [WIDTH-1:0] count_q;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q   <= {WIDTH{1'b0}};
            expired_q <= 1'b0;
        end
        else if (ce)
        begin
            if (!en || clear)
            begin
                count_q   <= {WIDTH{1'b0}};
                expired_q <= 1'b0;
            end
            else if (tick && !expired_q)
            begin
                count_q   <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
                expired_q <= (count_q == LIMIT[WIDTH-1:0] - 1'b1);
            end
        end
    end

endmodule // rstc_timer

`default_nettype wire

//--- bench/rstc_controller_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "rstc_regs.vh"
module rstc_controller_monitor (
    // Clock and bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // Sources and outputs
    input wire logic        sys_rst_n,
    input wire logic        ext_rst_n,
    input wire logic        comparator_out,
    input wire logic        fetch_valid,
    input wire logic [15:0] access_addr,
    input wire logic        security_violation,
    input wire logic        vbus_level,
    input wire logic        vbus_polarity_select,
    input wire logic        supply_monitor_en,
    input wire logic        watchdog_active
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // Shadow of the source enables
    // ------------------------------------------------------------
    logic cmp_en_q;
    logic usb_en_q;
    wire  wr_c = psel && penable && pwrite && ce && sys_rst_n
                 && paddr == `RSTC_CAUSE_ADDR;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) {cmp_en_q, usb_en_q} <= 2'b00;
        else if (!sys_rst_n) {cmp_en_q, usb_en_q} <= 2'b00;
        else if (wr_c) {cmp_en_q, usb_en_q} <= {pwdata[5], pwdata[7]};
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_pin; ce && !ext_rst_n |=> !sys_rst_n; endproperty
    a_pin: assert property (p_pin) else $error("pin low not in reset");
    property p_soft; wr_c && pwdata[4] |-> ##[1:3] !sys_rst_n; endproperty
    a_soft: assert property (p_soft) else $error("no soft reset");
    property p_cmp;
        ce && sys_rst_n && cmp_en_q && !comparator_out
        |-> ##[1:3] !sys_rst_n;
    endproperty
    a_cmp: assert property (p_cmp) else $error("no comparator reset");
    property p_vbus;
        ce && sys_rst_n && usb_en_q && vbus_level == vbus_polarity_select
        |-> ##[1:3] !sys_rst_n;
    endproperty
    a_vbus: assert property (p_vbus) else $error("no vbus reset");
    property p_fetch;
        ce && sys_rst_n && fetch_valid && access_addr > `RSTC_FLASH_TOP
        |-> ##[1:3] !sys_rst_n;
    endproperty
    a_fetch: assert property (p_fetch) else $error("no fetch reset");
    property p_sec;
        ce && sys_rst_n && security_violation |-> ##[1:3] !sys_rst_n;
    endproperty
    a_sec: assert property (p_sec) else $error("no security reset");
    property p_sup; $rose(presetn) |-> supply_monitor_en; endproperty
    a_sup: assert property (p_sup) else $error("supply monitor off");
    property p_wd; $rose(sys_rst_n) |-> watchdog_active; endproperty
    a_wd: assert property (p_wd) else $error("watchdog not enabled");
    property p_err;
        psel && penable && paddr != `RSTC_CAUSE_ADDR
        && paddr != `RSTC_WDCTL_ADDR && paddr != `RSTC_SUPPLY_ADDR |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("unmapped not flagged");
    c_rst: cover property ($fell(sys_rst_n));
    c_cmp: cover property (cmp_en_q && !comparator_out);
    c_err: cover property (pslverr);
endmodule // rstc_controller_monitor
bind rstc_controller rstc_controller_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pslverr(pslverr), .sys_rst_n(sys_rst_n), .ext_rst_n(ext_rst_n),
    .comparator_out(comparator_out), .fetch_valid(fetch_valid),
    .access_addr(access_addr), .security_violation(security_violation),
    .vbus_level(vbus_level), .vbus_polarity_select(vbus_polarity_select),
    .supply_monitor_en(supply_monitor_en),
    .watchdog_active(watchdog_active));
`default_nettype wire

//--- bench/rstc_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
// External reset circuit and system clock source
module rstc_ext_model (
    input  wire logic pclk,
    input  wire logic run,
    input  wire logic pin_req,
    output var  logic ext_rst_n,
    output var  logic system_clock
);
    initial system_clock = 1'b0;
    initial ext_rst_n = 1'b1;
    // Clock stands still when not run, so a stall is a real loss
    always @(posedge pclk) system_clock <= run ? ~system_clock : system_clock;
    always @(posedge pclk) ext_rst_n <= ~pin_req;
endmodule // rstc_ext_model
`default_nettype wire

//--- bench/reset_source_controller_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rstc_regs.vh"
module reset_source_controller_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic sys_rst_n, ext_rst_n, system_clock, cmp_out, fwe, xwr, crd, fet;
    logic sec, fwr, sup_en, ue, ubr, vbl, pol, wd_act, run, pin_req, err, ce;
    logic [15:0] aa;
    logic [7:0] tbl [12] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40,
                             8'h40, 8'h40, 8'h40, 8'h40, 8'h80, 8'h80};
    int n_mismatch = 0;
    int total_checks = 0;
    logic [7:0] exp_q [$];
    rstc_controller #(.CLKLOSS_CYCLES(50), .HOLD_CYCLES(8), .WDOG_LIMIT(4)) u_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_rst_n(ext_rst_n), .sys_rst_n(sys_rst_n),
        .system_clock(system_clock), .comparator_out(cmp_out),
        .flash_write_enable(fwe), .xdata_wr_valid(xwr), .code_rd_valid(crd),
        .fetch_valid(fet), .access_addr(aa), .security_violation(sec),
        .flash_wr_erase_req(fwr), .supply_monitor_en(sup_en),
        .usb_enabled(ue), .usb_bus_reset(ubr), .vbus_level(vbl),
        .vbus_polarity_select(pol), .watchdog_active(wd_act));
    rstc_ext_model u_ext (.pclk(pclk), .run(run), .pin_req(pin_req),
        .ext_rst_n(ext_rst_n), .system_clock(system_clock));
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin n_mismatch++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic clear_src;
        {fwe, xwr, crd, fet, sec, fwr, ue, ubr, run} <= 9'h000;
        cmp_out <= 1'b1;
        vbl <= ~pol;
    endtask
    task automatic trigger(input int k);
        case (k)
            0: begin pin_req <= 1'b1; repeat (20) @(posedge pclk); pin_req <= 1'b0; end
            1: apb(1'b1, `RSTC_CAUSE_ADDR, 32'h04);
            2: run <= 1'b1;
            3: apb(1'b1, `RSTC_CAUSE_ADDR, 32'h10);
            4: begin
                apb(1'b1, `RSTC_CAUSE_ADDR, 32'h20);
                apb(1'b0, `RSTC_CAUSE_ADDR, 32'h0);
                chk("cause_after_enable", 32'h10, rd);
                cmp_out <= 1'b0;
            end
            5: begin aa <= 16'h3E00 + 16'($urandom % 16'hC200); fet <= 1'b1; end
            6: begin aa <= 16'hFFFF; crd <= 1'b1; end
            7: begin aa <= 16'h3E00; fwe <= 1'b1; xwr <= 1'b1; end
            8: sec <= 1'b1;
            9: begin apb(1'b1, `RSTC_SUPPLY_ADDR, 32'h0); fwr <= 1'b1; end
            10: begin
                apb(1'b1, `RSTC_CAUSE_ADDR, 32'h80);
                ubr <= 1'b1;
                repeat (10) @(posedge pclk);
                chk("usb_disabled_run", 32'h1, 32'(sys_rst_n));
                ue <= 1'b1;
            end
            default: begin apb(1'b1, `RSTC_CAUSE_ADDR, 32'h80); vbl <= pol; end
        endcase
    endtask
    task automatic wait_rst;
        int i;
        for (i = 0; i < 500 && sys_rst_n !== 1'b0; i++) @(posedge pclk);
        chk("sys_rst_n_low", 32'h0, 32'(sys_rst_n));
        clear_src();
        for (i = 0; i < 500 && sys_rst_n !== 1'b1; i++) @(posedge pclk);
        repeat (2) @(posedge pclk);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pin_req, aa} = '0;
        rd = '0;
        err = 1'b0;
        ce = 1'b1;
        void'($urandom(32'h8cf1));
        pol = 1'($urandom % 2);
        clear_src();
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `RSTC_CAUSE_ADDR, 32'h0);
        chk("cause_por", 32'h02, rd);
        apb(1'b0, `RSTC_WDCTL_ADDR, 32'h0);
        chk("wdctl_rst", 32'h01, rd);
        apb(1'b0, `RSTC_SUPPLY_ADDR, 32'h0);
        chk("supply_rst", 32'h01, rd);
        apb(1'b0, 12'h3C8, 32'h0);
        chk("unmapped_err", 32'h1, 32'(err));
        chk("unmapped_data", 32'h0, rd);
        for (int k = 0; k < 12; k++)
        begin
            trigger(k);
            exp_q.push_back(tbl[k]);
            wait_rst();
            chk("wdog_active", 32'h1, 32'(wd_act));
            apb(1'b0, `RSTC_CAUSE_ADDR, 32'h0);
            chk("cause", 32'(exp_q.pop_front()), rd);
        end
        // Frozen clock enable: no bus answer, no reset taken
        {ce, sec} <= 2'b01;
        repeat (10) @(posedge pclk);
        chk("frozen_ready", 32'h0, 32'(pready));
        chk("frozen_sys_rst_n", 32'h1, 32'(sys_rst_n));
        {ce, sec} <= 2'b10;
        apb(1'b1, `RSTC_CAUSE_ADDR, 32'h49);
        apb(1'b0, `RSTC_CAUSE_ADDR, 32'h0);
        chk("cause_read_only", 32'h80, rd);
        print_verdict();
    end
endmodule // reset_source_controller_tb_top
`default_nettype wire
